//--- hdl/prf_result_status.sv
// sample queue and result, status and queue register logic of the barometer
// Summary of operation
// - status flags refresh with every new sample period, independent of hold setting
// - pressure-available bit 1 sets on new pressure, clears on pressure high-byte read
// - temperature-available bit 0 sets on new temperature, clears on temperature high read
// - pressure-overrun bit 5 sets when new pressure overwrites unread one; clears on high read
// - temperature-overrun bit 4 likewise for temperature, clears on temperature high read
// - pressure is 24 bits over read-only bytes 28h, 29h, 2Ah
// - temperature is 16 bits over two read-only bytes, high byte at 2Ch
// - queue control at 2Eh: mode in bits 7..5, watermark in bits 4..0
// - mode 000 bypasses queue; 001 fills queue and stops when full
// - 010 streams keeping newest; 011 streams until trigger deasserts, then stops-when-full
// - 100 bypasses then streams after trigger; 111 bypasses then stops-when-full
// - 110 gives running-average pressure; 101 is reserved
// - in averaging, watermark codes 1,3,7,15,31 give windows of 2..32 samples
// - during averaging, individual queue entries cannot be read
// - queue status bit 7 is one when level reaches or exceeds watermark
// - queue status bit 6 is one when queue is full
// - queue status bit 5 is one when queue is empty
// - queue status bits 4..0 give the stored sample count, reading 0 when all 32 entries are held
// - threshold low byte at 30h, unsigned, hPa equals value over 16
// - with hold enabled, a partly read result stays frozen until fully read, except a queue head shown while the queue is active
// - queue holds 32 entries of 24 bits taken from pressure results
// - each queue read presents the oldest entry in the pressure result bytes
// - with queue active, read address wraps from 2Ah back to 28h
`timescale 1ns/1ps

// first-word-fall-through queue with valid and ready on both sides
module prf_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CW-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [CW-1:0] FULL_LEVEL = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic push;
  logic pop;

  // a full queue still accepts when the head leaves in the same cycle
  assign in_ready = (count_q != FULL_LEVEL) || out_ready;
  assign out_valid = (count_q != '0);
  assign out_data = mem[rd_ptr_q];
  assign level = count_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule : prf_fifo

module prf_result_status #(
  parameter int DEPTH = prf_pkg::QUEUE_DEPTH
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_RD,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic [7:0] NEXT_ADDR,
  input wire logic HOLD_RESULT_UNTIL_PAIR_READ,
  input wire logic PRESS_VALID,
  input wire logic [24:0] PRESS_RAW,
  input wire logic TEMP_VALID,
  input wire logic [15:0] TEMP_RAW,
  input wire logic QUEUE_TRIGGER,
  output logic [7:0] THRESHOLD_LOW
);
  localparam int PW = prf_pkg::PRESS_W;
  localparam int TW = prf_pkg::TEMP_W;
  localparam int CW = $clog2(DEPTH + 1);
  localparam int SW = PW + 6;
  localparam logic [CW-1:0] FULL_LEVEL = CW'(DEPTH);
  logic [7:0] qctrl_q;
  logic [7:0] thr_q;
  logic pda_q, tda_q, por_q, tor_q;
  logic trig_q, trig_seen_q;
  logic [PW-1:0] p_new_q, pres_q;
  logic [TW-1:0] t_new_q, temp_q;
  logic [2:0] p_part_q;
  logic [1:0] t_part_q;
  logic signed [SW-1:0] sum_q;
  logic [7:0] rdata_q, next_q;
  prf_pkg::prf_mode_t mode, eff;
  logic [4:0] wtm;
  logic [CW-1:0] level, window;
  logic [2:0] shift;
  logic q_in_ready, q_out_valid, q_out_ready, q_push, q_flush;
  logic [PW-1:0] q_head, p_clip, avg;
  logic queue_act, mean_act, stream_act;
  logic rd_phi, rd_thi, p_lock, t_lock;
  logic signed [SW-1:0] sum_d;
  logic [7:0] rmux;
  assign mode = prf_pkg::prf_mode_t'(qctrl_q[prf_pkg::QC_MODE_MSB:prf_pkg::QC_MODE_LSB]);
  assign wtm = qctrl_q[prf_pkg::QC_WTM_MSB:prf_pkg::QC_WTM_LSB];
  assign rd_phi = REG_RD && (REG_ADDR == prf_pkg::ADDR_PRESS_HIGH);
  assign rd_thi = REG_RD && (REG_ADDR == prf_pkg::ADDR_TEMP_HIGH);
  // clip the wide raw sample to the signed 24-bit range
  always_comb begin
    if (PRESS_RAW[24] != PRESS_RAW[23]) begin
      p_clip = PRESS_RAW[24] ? {1'b1, {(PW-1){1'b0}}} : {1'b0, {(PW-1){1'b1}}};
    end else begin
      p_clip = PRESS_RAW[PW-1:0];
    end
  end
  // effective mode after the trigger has dropped
  always_comb begin
    unique case (mode)
      prf_pkg::QM_STREAM_FIFO: eff = trig_seen_q ? prf_pkg::QM_FIFO : prf_pkg::QM_STREAM;
      prf_pkg::QM_BYPASS_STREAM: eff = trig_seen_q ? prf_pkg::QM_STREAM : prf_pkg::QM_BYPASS;
      prf_pkg::QM_BYPASS_FIFO: eff = trig_seen_q ? prf_pkg::QM_FIFO : prf_pkg::QM_BYPASS;
      prf_pkg::QM_RESERVED: eff = prf_pkg::QM_BYPASS;
      default: eff = mode;
    endcase
  end
  assign queue_act = (eff == prf_pkg::QM_FIFO) || (eff == prf_pkg::QM_STREAM);
  assign stream_act = (eff == prf_pkg::QM_STREAM);
  assign mean_act = (eff == prf_pkg::QM_MEAN);
  // averaging window: a run of ones in the watermark code sets 2^n samples
  always_comb begin
    shift = 3'(wtm[0]) + 3'(wtm[1]) + 3'(wtm[2]) + 3'(wtm[3]) + 3'(wtm[4]);
    window = CW'(wtm) + 1'b1;
  end
  // queue feeding: bypass never fills, stop-when-full relies on in_ready
  assign q_push = PRESS_VALID && (queue_act || mean_act);
  assign q_flush = REG_WR && (REG_ADDR == prf_pkg::ADDR_QUEUE_CTRL);
  // oldest entry leaves on a high-byte read, on a full stream, or at window end
  assign q_out_ready = (queue_act && rd_phi)
    || (stream_act && PRESS_VALID && (level == FULL_LEVEL))
    || (mean_act && PRESS_VALID && (level >= window));
  prf_fifo #(
    .WIDTH(PW),
    .DEPTH(DEPTH),
    .CW(CW)
  ) u_queue (
    .clk(CLK),
    .rst(RST),
    .clear(q_flush),
    .in_valid(q_push),
    .in_ready(q_in_ready),
    .in_data(p_clip),
    .out_valid(q_out_valid),
    .out_ready(q_out_ready),
    .out_data(q_head),
    .level(level)
  );
  // running sum over the window, updated with the sample that enters
  always_comb begin
    sum_d = sum_q;
    if (mean_act && PRESS_VALID) begin
      sum_d = sum_d + SW'(signed'(p_clip));
      if (q_out_ready && q_out_valid) begin
        sum_d = sum_d - SW'(signed'(q_head));
      end
    end
    avg = PW'(sum_d >>> shift);
  end

  always_ff @(posedge CLK) begin
    if (RST || q_flush) begin
      sum_q <= '0;
    end else if (mean_act) begin
      sum_q <= sum_d;
    end
  end
  // writable registers; reserved and read-only addresses ignore writes
  always_ff @(posedge CLK) begin
    if (RST) begin
      qctrl_q <= prf_pkg::RST_QUEUE_CTRL;
      thr_q <= prf_pkg::RST_THRESH_LOW;
    end else if (REG_WR) begin
      if (REG_ADDR == prf_pkg::ADDR_QUEUE_CTRL) begin
        qctrl_q <= REG_WDATA;
      end
      if (REG_ADDR == prf_pkg::ADDR_THRESH_LOW) begin
        thr_q <= REG_WDATA;
      end
    end
  end
  // trigger falls once per arming; a new control write rearms it
  always_ff @(posedge CLK) begin
    if (RST) begin
      trig_q <= 1'b0;
      trig_seen_q <= 1'b0;
    end else begin
      trig_q <= QUEUE_TRIGGER;
      if (q_flush) begin
        trig_seen_q <= 1'b0;
      end else if (trig_q && !QUEUE_TRIGGER) begin
        trig_seen_q <= 1'b1;
      end
    end
  end
  // availability and overrun flags; a new sample beats a clearing read
  always_ff @(posedge CLK) begin
    if (RST) begin
      pda_q <= 1'b0;
      por_q <= 1'b0;
    end else if (PRESS_VALID) begin
      pda_q <= 1'b1;
      if (pda_q) begin
        por_q <= 1'b1;
      end else if (rd_phi) begin
        por_q <= 1'b0;
      end
    end else if (rd_phi) begin
      pda_q <= 1'b0;
      por_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      tda_q <= 1'b0;
      tor_q <= 1'b0;
    end else if (TEMP_VALID) begin
      tda_q <= 1'b1;
      if (tda_q) begin
        tor_q <= 1'b1;
      end else if (rd_thi) begin
        tor_q <= 1'b0;
      end
    end else if (rd_thi) begin
      tda_q <= 1'b0;
      tor_q <= 1'b0;
    end
  end

  // byte-read tracking for the hold option; all parts read releases it
  // idles while hold is off, so stale single-byte reads never lock later
  always_ff @(posedge CLK) begin
    if (RST || !HOLD_RESULT_UNTIL_PAIR_READ) begin
      p_part_q <= '0;
      t_part_q <= '0;
    end else begin
      if (REG_RD && (REG_ADDR >= prf_pkg::ADDR_PRESS_LOW) && (REG_ADDR <= prf_pkg::ADDR_PRESS_HIGH)) begin
        p_part_q <= ((p_part_q | (3'h1 << REG_ADDR[1:0])) == 3'h7) ? 3'h0 : (p_part_q | (3'h1 << REG_ADDR[1:0]));
      end
      if (REG_RD && (REG_ADDR == prf_pkg::ADDR_TEMP_LOW)) begin
        t_part_q <= t_part_q[1] ? 2'h0 : 2'h1;
      end else if (rd_thi) begin
        t_part_q <= t_part_q[0] ? 2'h0 : 2'h2;
      end
    end
  end

  assign p_lock = HOLD_RESULT_UNTIL_PAIR_READ && (p_part_q != '0);
  assign t_lock = HOLD_RESULT_UNTIL_PAIR_READ && (t_part_q != '0);
  // newest value waits in a shadow while the visible copy is held
  always_ff @(posedge CLK) begin
    if (RST) begin
      p_new_q <= '0;
      t_new_q <= '0;
      pres_q <= '0;
      temp_q <= '0;
    end else begin
      if (PRESS_VALID) begin
        p_new_q <= mean_act ? avg : p_clip;
      end
      if (TEMP_VALID) begin
        t_new_q <= TEMP_RAW;
      end
      if (!p_lock) begin
        pres_q <= p_new_q;
      end
      if (!t_lock) begin
        temp_q <= t_new_q;
      end
    end
  end
  // read mux; queue head is shown only while the queue is active
  always_comb begin
    logic [PW-1:0] pv;
    pv = (queue_act && q_out_valid) ? q_head : pres_q;
    unique case (REG_ADDR)
      prf_pkg::ADDR_STATUS: rmux = {2'b00, por_q, tor_q, 2'b00, pda_q, tda_q};
      prf_pkg::ADDR_PRESS_LOW: rmux = pv[7:0];
      prf_pkg::ADDR_PRESS_MID: rmux = pv[15:8];
      prf_pkg::ADDR_PRESS_HIGH: rmux = pv[23:16];
      prf_pkg::ADDR_TEMP_LOW: rmux = temp_q[7:0];
      prf_pkg::ADDR_TEMP_HIGH: rmux = temp_q[15:8];
      prf_pkg::ADDR_QUEUE_CTRL: rmux = qctrl_q;
      prf_pkg::ADDR_QUEUE_STATUS: rmux = {(level >= CW'(wtm)), (level == FULL_LEVEL),
        (level == '0), level[prf_pkg::QS_LEVEL_MSB:0]};
      prf_pkg::ADDR_THRESH_LOW: rmux = thr_q;
      default: rmux = prf_pkg::RDATA_UNMAPPED;
    endcase
  end
  // registered read data and next burst address
  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_q <= prf_pkg::RDATA_UNMAPPED;
      next_q <= '0;
    end else if (REG_RD) begin
      rdata_q <= rmux;
      if (queue_act && (REG_ADDR == prf_pkg::ADDR_PRESS_HIGH)) begin
        next_q <= prf_pkg::ADDR_PRESS_LOW;
      end else begin
        next_q <= REG_ADDR + 8'h01;
      end
    end
  end
  assign REG_RDATA = rdata_q;
  assign NEXT_ADDR = next_q;
  assign THRESHOLD_LOW = thr_q;

  // checks
  property p_pda_set;
    @(posedge CLK) disable iff (RST) PRESS_VALID |=> pda_q;
  endproperty
  a_pda_set: assert property (p_pda_set) else $error("pressure flag not set");
  property p_pda_clr;
    @(posedge CLK) disable iff (RST) rd_phi && !PRESS_VALID |=> !pda_q && !por_q;
  endproperty
  a_pda_clr: assert property (p_pda_clr) else $error("pressure flags not cleared");
  property p_tda;
    @(posedge CLK) disable iff (RST) (TEMP_VALID |=> tda_q) and (rd_thi && !TEMP_VALID |=> !tda_q);
  endproperty
  a_tda: assert property (p_tda) else $error("temperature flag wrong");
  property p_por;
    @(posedge CLK) disable iff (RST) PRESS_VALID && pda_q |=> por_q;
  endproperty
  a_por: assert property (p_por) else $error("pressure overrun missed");
  property p_tor;
    @(posedge CLK) disable iff (RST) TEMP_VALID && tda_q |=> tor_q;
  endproperty
  a_tor: assert property (p_tor) else $error("temperature overrun missed");
  property p_full;
    @(posedge CLK) disable iff (RST)
      REG_RD && REG_ADDR == prf_pkg::ADDR_QUEUE_STATUS |=> REG_RDATA[6] == ($past(level) == FULL_LEVEL);
  endproperty
  a_full: assert property (p_full) else $error("full bit wrong");
  property p_empty;
    @(posedge CLK) disable iff (RST)
      REG_RD && REG_ADDR == prf_pkg::ADDR_QUEUE_STATUS |=> REG_RDATA[5] == ($past(level) == '0);
  endproperty
  a_empty: assert property (p_empty) else $error("empty bit wrong");
  property p_stop_full;
    @(posedge CLK) disable iff (RST)
      eff == prf_pkg::QM_FIFO && level == FULL_LEVEL && !rd_phi && !q_flush |=> $stable(level);
  endproperty
  a_stop_full: assert property (p_stop_full) else $error("full queue kept filling");
  property p_hold;
    @(posedge CLK) disable iff (RST) p_lock |=> $stable(pres_q);
  endproperty
  a_hold: assert property (p_hold) else $error("held result changed");
  property p_wrap;
    @(posedge CLK) disable iff (RST) rd_phi && queue_act |=> NEXT_ADDR == prf_pkg::ADDR_PRESS_LOW;
  endproperty
  a_wrap: assert property (p_wrap) else $error("burst address did not wrap");
endmodule : prf_result_status

//--- hdl/prf_pkg.sv
// constants for the pressure result, status and sample queue logic
package prf_pkg;
  // register addresses
  localparam logic [7:0] ADDR_STATUS = 8'h27;
  localparam logic [7:0] ADDR_PRESS_LOW = 8'h28;
  localparam logic [7:0] ADDR_PRESS_MID = 8'h29;
  localparam logic [7:0] ADDR_PRESS_HIGH = 8'h2A;
  localparam logic [7:0] ADDR_TEMP_LOW = 8'h2B;
  localparam logic [7:0] ADDR_TEMP_HIGH = 8'h2C;
  localparam logic [7:0] ADDR_QUEUE_CTRL = 8'h2E;
  localparam logic [7:0] ADDR_QUEUE_STATUS = 8'h2F;
  localparam logic [7:0] ADDR_THRESH_LOW = 8'h30;
  // status register bit positions
  localparam int ST_POR_BIT = 5;
  localparam int ST_TOR_BIT = 4;
  localparam int ST_PDA_BIT = 1;
  localparam int ST_TDA_BIT = 0;
  // queue control and status fields
  localparam int QC_MODE_MSB = 7;
  localparam int QC_MODE_LSB = 5;
  localparam int QC_WTM_MSB = 4;
  localparam int QC_WTM_LSB = 0;
  localparam int QS_WTM_BIT = 7;
  localparam int QS_FULL_BIT = 6;
  localparam int QS_EMPTY_BIT = 5;
  localparam int QS_LEVEL_MSB = 4;
  // reset values
  localparam logic [7:0] RST_QUEUE_CTRL = 8'h00;
  localparam logic [7:0] RST_THRESH_LOW = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  // widths
  localparam int PRESS_W = 24;
  localparam int TEMP_W = 16;
  localparam int QUEUE_DEPTH = 32;
  // queue mode codes
  typedef enum logic [2:0] {
    QM_BYPASS = 3'b000,
    QM_FIFO = 3'b001,
    QM_STREAM = 3'b010,
    QM_STREAM_FIFO = 3'b011,
    QM_BYPASS_STREAM = 3'b100,
    QM_RESERVED = 3'b101,
    QM_MEAN = 3'b110,
    QM_BYPASS_FIFO = 3'b111
  } prf_mode_t;
endpackage : prf_pkg

//--- test/prf_sample_src.sv
// sensor front-end model that delivers pressure and temperature samples
`timescale 1ns/1ps

module prf_sample_src (
  input wire logic clk,
  output logic press_valid,
  output logic [24:0] press_raw,
  output logic temp_valid,
  output logic [15:0] temp_raw
);
  // idle values at time zero
  initial begin
    press_valid = 1'b0;
    press_raw = 25'h0000000;
    temp_valid = 1'b0;
    temp_raw = 16'h0000;
  end

  // one-cycle pulse per sample; data inverted afterwards so stale values are never trusted
  task automatic press(input logic [24:0] v);
    @(posedge clk);
    press_valid <= 1'b1;
    press_raw <= v;
    @(posedge clk);
    press_valid <= 1'b0;
    press_raw <= ~v;
    repeat (3) @(posedge clk);
  endtask : press

  // temperature sample, same pacing as pressure
  task automatic temp(input logic [15:0] v);
    @(posedge clk);
    temp_valid <= 1'b1;
    temp_raw <= v;
    @(posedge clk);
    temp_valid <= 1'b0;
    temp_raw <= ~v;
    repeat (3) @(posedge clk);
  endtask : temp
endmodule : prf_sample_src

//--- test/prf_result_status_bench.sv
// self-checking bench for the result, status and sample queue registers
`timescale 1ns/1ps

module prf_result_status_bench;
  logic CLK;
  logic RST;
  logic [7:0] REG_ADDR;
  logic REG_RD;
  logic REG_WR;
  logic [7:0] REG_WDATA;
  logic [7:0] REG_RDATA;
  logic [7:0] NEXT_ADDR;
  logic HOLD_RESULT_UNTIL_PAIR_READ;
  logic PRESS_VALID;
  logic [24:0] PRESS_RAW;
  logic TEMP_VALID;
  logic [15:0] TEMP_RAW;
  logic QUEUE_TRIGGER;
  logic [7:0] THRESHOLD_LOW;
  int err_count = 0;
  int checks = 0;
  logic [2:0] tmode [5] = '{3'b011, 3'b100, 3'b111, 3'b000, 3'b101};
  int tpre [5] = '{2, 0, 0, 0, 0};
  int tpost [5] = '{4, 2, 2, 0, 0};

  // 100 MHz clock
  always #5 CLK = ~CLK;

  prf_result_status prf_result_status_i (
    .CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_WR(REG_WR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .NEXT_ADDR(NEXT_ADDR),
    .HOLD_RESULT_UNTIL_PAIR_READ(HOLD_RESULT_UNTIL_PAIR_READ), .PRESS_VALID(PRESS_VALID),
    .PRESS_RAW(PRESS_RAW), .TEMP_VALID(TEMP_VALID), .TEMP_RAW(TEMP_RAW),
    .QUEUE_TRIGGER(QUEUE_TRIGGER), .THRESHOLD_LOW(THRESHOLD_LOW)
  );

  prf_sample_src prf_sample_src_i (
    .clk(CLK), .press_valid(PRESS_VALID), .press_raw(PRESS_RAW),
    .temp_valid(TEMP_VALID), .temp_raw(TEMP_RAW)
  );

  // verdict and end of run, shared by main sequence and watchdog
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one byte read: strobe for one cycle, data valid one cycle later
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1;
    chk(REG_RDATA, exp);
  endtask : rc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask : wr

  // whole pressure result, low byte first
  task automatic rp(input logic [23:0] v);
    rc(8'h28, v[7:0]);
    rc(8'h29, v[15:8]);
    rc(8'h2A, v[23:16]);
  endtask : rp

  // queue status byte expected for a level with watermark 1
  function automatic logic [7:0] qs1(input int lvl);
    return (lvl == 0) ? 8'h20 : (8'h80 | 8'(lvl));
  endfunction : qs1

  // watchdog sized well above the expected run length
  initial begin
    #500us;
    err_count++;
    complete_run();
  end

  initial begin
    // idle levels at time zero with reset asserted
    CLK = 1'b0;
    RST <= 1'b1;
    REG_ADDR <= 8'h00;
    REG_RD <= 1'b0;
    REG_WR <= 1'b0;
    REG_WDATA <= 8'h00;
    HOLD_RESULT_UNTIL_PAIR_READ <= 1'b0;
    QUEUE_TRIGGER <= 1'b0;
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    // reset values and unmapped read
    rc(8'h27, 8'h00);
    rc(8'h2E, 8'h00);
    rc(8'h30, 8'h00);
    rc(8'h3F, 8'h00);
    chk(THRESHOLD_LOW, 8'h00);
    wr(8'h30, 8'hA5);
    wr(8'h27, 8'hFF);
    rc(8'h30, 8'hA5);
    chk(THRESHOLD_LOW, 8'hA5);
    rc(8'h27, 8'h00);
    $display("test registers done");
    // bypass pressure, flags, overrun
    prf_sample_src_i.press(25'h0123456);
    rc(8'h27, 8'h02);
    rp(24'h123456);
    chk(NEXT_ADDR, 8'h2B);
    rc(8'h27, 8'h00);
    prf_sample_src_i.press(25'h0000001);
    prf_sample_src_i.press(25'h0000002);
    rc(8'h27, 8'h22);
    rc(8'h2A, 8'h00);
    rc(8'h27, 8'h00);
    prf_sample_src_i.temp(16'h7F00);
    prf_sample_src_i.temp(16'h8001);
    rc(8'h27, 8'h11);
    rc(8'h2B, 8'h01);
    rc(8'h2C, 8'h80);
    rc(8'h27, 8'h00);
    prf_sample_src_i.press(25'h0FFFFFF);
    rp(24'h7FFFFF);
    prf_sample_src_i.press(25'h1000000);
    rp(24'h800000);
    $display("test status done");
    // stop-when-full queue with watermark 3
    wr(8'h2E, 8'h23);
    rc(8'h2E, 8'h23);
    for (int k = 0; k < 33; k++) begin
      prf_sample_src_i.press(25'(k + 1));
      if (k == 2) rc(8'h2F, 8'h83);
    end
    rc(8'h2F, 8'hC0);
    rp(24'h000001);
    chk(NEXT_ADDR, 8'h28);
    rc(8'h2F, 8'h9F);
    for (int k = 1; k < 32; k++) rp(24'(k + 1));
    rc(8'h2F, 8'h20);
    $display("test fifo done");
    // stream keeps the newest samples
    wr(8'h2E, 8'h40);
    for (int k = 0; k < 34; k++) prf_sample_src_i.press(25'(k + 1));
    rc(8'h2F, 8'hC0);
    rp(24'h000003);
    $display("test stream done");
    // trigger driven modes plus bypass and reserved codes
    for (int m = 0; m < 5; m++) begin
      @(posedge CLK);
      QUEUE_TRIGGER <= 1'b1;
      wr(8'h2E, {tmode[m], 5'h01});
      prf_sample_src_i.press(25'h0000010);
      prf_sample_src_i.press(25'h0000011);
      rc(8'h2F, qs1(tpre[m]));
      @(posedge CLK);
      QUEUE_TRIGGER <= 1'b0;
      prf_sample_src_i.press(25'h0000012);
      prf_sample_src_i.press(25'h0000013);
      rc(8'h2F, qs1(tpost[m]));
    end
    $display("test trigger done");
    // running average over two then four samples, entries not readable
    wr(8'h2E, 8'hC1);
    prf_sample_src_i.press(25'h000000A);
    prf_sample_src_i.press(25'h0000014);
    rp(24'h00000F);
    rp(24'h00000F);
    wr(8'h2E, 8'hC3);
    for (int k = 0; k < 4; k++) prf_sample_src_i.press(25'(4 * k));
    rp(24'h000006);
    $display("test mean done");
    // hold a partly read result while flags keep updating
    wr(8'h2E, 8'h00);
    rc(8'h2C, 8'h80);
    @(posedge CLK);
    HOLD_RESULT_UNTIL_PAIR_READ <= 1'b1;
    prf_sample_src_i.press(25'h00A0B0C);
    rc(8'h28, 8'h0C);
    prf_sample_src_i.press(25'h0111111);
    rc(8'h27, 8'h22);
    rc(8'h29, 8'h0B);
    rc(8'h2A, 8'h0A);
    prf_sample_src_i.press(25'h0222222);
    rp(24'h222222);
    $display("test hold done");
    complete_run();
  end
endmodule : prf_result_status_bench
